// file: sscl_cfg.svh
// constants for the serial switch control latch: widths, stages, resets
// assumes it is included by the package and the top module only
`ifndef SSCL_CFG_SVH
`define SSCL_CFG_SVH

// =====================================================================
// sizes
`define SSCL_CHANNELS   32
`define SSCL_LAST_STAGE 31

// =====================================================================
// reset values
`define SSCL_SHIFT_RST  32'h0000_0000
`define SSCL_LATCH_RST  32'h0000_0000
// pin order: clear, strobe_n, shift_clk, serial_in; strobe idles high
`define SSCL_PINS_RST   4'h4

`endif

// file: sscl_pkg.sv
// types shared by the serial switch control latch files
// assumes sscl_cfg.svh sits in the include path
package sscl_pkg;
  `include "sscl_cfg.svh"

  // =====================================================================
  // pin bundle, one bit per controller pin
  typedef struct packed {
    logic clear;
    logic strobe_n;
    logic shift_clk;
    logic serial_in;
  } sscl_pins_t;

  // one bit per switch channel
  typedef logic [`SSCL_CHANNELS-1:0] sscl_word_t;
endpackage

// file: sscl_skid.sv
// two-entry buffer with valid and ready on both sides
// assumes one clock; en low freezes every flip-flop
`timescale 1ns/1ps
module sscl_skid #(
  parameter int WIDTH = 32
) (
  // clock, reset, enable
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  logic [WIDTH-1:0] skid_data;
  logic             skid_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_skid_data;
  logic             next_skid_valid;

  // ready is a flop: the second entry catches a word sent while stalled
  assign in_ready_o = ~skid_valid;

  // =====================================================================
  // next-value logic
  always_comb begin
    next_out_data   = out_data_o;
    next_out_valid  = out_valid_o;
    next_skid_data  = skid_data;
    next_skid_valid = skid_valid;
    if (!out_valid_o || out_ready_i) begin
      // head is free or leaving: refill from skid first to keep order
      if (skid_valid) begin
        next_out_data   = skid_data;
        next_out_valid  = 1'b1;
        next_skid_valid = 1'b0;
      end else begin
        next_out_data   = in_data_i;
        next_out_valid  = in_valid_i;
      end
    end else if (in_valid_i && !skid_valid) begin
      // head stalled: park the word rather than drop it
      next_skid_data  = in_data_i;
      next_skid_valid = 1'b1;
    end
  end

  // registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_data_o  <= '0;
      out_valid_o <= 1'b0;
      skid_data   <= '0;
      skid_valid  <= 1'b0;
    end else if (clk_en_i) begin
      out_data_o  <= next_out_data;
      out_valid_o <= next_out_valid;
      skid_data   <= next_skid_data;
      skid_valid  <= next_skid_valid;
    end
  end
endmodule

// file: sscl_top.sv
// serial switch control latch: pin sync, shift register, latch, buffer
// assumes the controller pins are asynchronous to clk_sys_i and that
// the shift clock is slow enough for three-flop sampling at 20 MHz
`timescale 1ns/1ps
`include "sscl_cfg.svh"
module sscl_top (
  // clock, reset, enable
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              clk_en_i,
  // controller pins
  input  wire logic              serial_in_i,
  input  wire logic              shift_clk_i,
  input  wire logic              latch_strobe_n_i,
  input  wire logic              force_all_off_i,
  // switch controls and cascade output
  output sscl_pkg::sscl_word_t   channel_terminal_o,
  output logic                   serial_out_o,
  // buffered switch-state updates
  output sscl_pkg::sscl_word_t   state_word_o,
  output logic                   state_valid_o,
  input  wire logic              state_ready_i
);
  import sscl_pkg::*;

  // =====================================================================
  // declarations
  sscl_pins_t pins_raw;
  sscl_pins_t sync_a;
  sscl_pins_t sync_b;
  sscl_pins_t sync_c;
  sscl_pins_t pins_s;
  sscl_pins_t next_pins_s;
  logic       shift_rise;
  sscl_word_t shift_stage_bits;
  sscl_word_t next_shift;
  logic       next_serial_out;
  sscl_word_t latch_bits;
  sscl_word_t next_latch;
  logic       push_pend;
  logic       next_push_pend;
  logic       buf_ready;

  // shift one bit in at stage 0, stage 31 falls out
  function automatic sscl_word_t shift_in(input sscl_word_t w,
                                          input logic       b);
    shift_in = {w[`SSCL_LAST_STAGE-1:0], b};
  endfunction

  assign pins_raw = '{clear: force_all_off_i, strobe_n: latch_strobe_n_i,
                      shift_clk: shift_clk_i, serial_in: serial_in_i};

  // =====================================================================
  // pin synchroniser: three flops, take a change once b and c agree
  always_comb begin
    next_pins_s = pins_s;
    for (int i = 0; i < $bits(sscl_pins_t); i++) begin
      if (sync_b[i] == sync_c[i]) begin
        next_pins_s[i] = sync_c[i];
      end
    end
  end

  // sync_a is read only by sync_b, to keep metastability contained
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= `SSCL_PINS_RST;
      sync_b <= `SSCL_PINS_RST;
      sync_c <= `SSCL_PINS_RST;
      pins_s <= `SSCL_PINS_RST;
    end else if (clk_en_i) begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
      pins_s <= next_pins_s;
    end
  end

  // rising edge of the filtered shift clock
  assign shift_rise = next_pins_s.shift_clk & ~pins_s.shift_clk;

  // =====================================================================
  // shift register and cascade output
  always_comb begin
    next_shift = shift_stage_bits;
    if (shift_rise) begin
      next_shift = shift_in(shift_stage_bits, next_pins_s.serial_in);
    end
    // cascade bit taken from the same next value, so it never lags
    next_serial_out = next_shift[`SSCL_LAST_STAGE];
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_stage_bits <= `SSCL_SHIFT_RST;
      serial_out_o     <= 1'b0;
    end else if (clk_en_i) begin
      shift_stage_bits <= next_shift;
      serial_out_o     <= next_serial_out;
    end
  end

  // =====================================================================
  // latch: clear first, then transparent while strobe low, else hold
  always_comb begin
    next_latch = latch_bits;
    if (next_pins_s.clear) begin
      next_latch = `SSCL_LATCH_RST;
    end else if (!next_pins_s.strobe_n) begin
      // last value seen while low is what the strobe rise keeps
      next_latch = next_shift;
    end
  end

  // channel n driven only by latch bit n, one means on
  assign channel_terminal_o = latch_bits;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_bits <= `SSCL_LATCH_RST;
    end else if (clk_en_i) begin
      latch_bits <= next_latch;
    end
  end

  // =====================================================================
  // update feed: a changed switch word is queued; while the buffer is
  // full the latest word waits here, older changes are merged away
  always_comb begin
    next_push_pend = push_pend & ~buf_ready;
    if (next_latch != latch_bits) begin
      next_push_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      push_pend <= 1'b0;
    end else if (clk_en_i) begin
      push_pend <= next_push_pend;
    end
  end

  sscl_skid #(
    .WIDTH (`SSCL_CHANNELS)
  ) u_skid (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (push_pend),
    .in_ready_o  (buf_ready),
    .in_data_i   (latch_bits),
    .out_valid_o (state_valid_o),
    .out_ready_i (state_ready_i),
    .out_data_o  (state_word_o)
  );

  // =====================================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  shift_step_a: assert property (
    (clk_en_i && shift_rise) |=>
      shift_stage_bits == {$past(shift_stage_bits[30:0]),
                           $past(next_pins_s.serial_in)})
    else $error("shift register did not advance on shift clock rise");

  strobe_capture_a: assert property (
    (clk_en_i && !next_pins_s.clear && !next_pins_s.strobe_n) ##1
    (clk_en_i && !next_pins_s.clear && next_pins_s.strobe_n) |=>
      channel_terminal_o == $past(shift_stage_bits))
    else $error("strobe rise did not keep the shift contents");

  latch_transp_a: assert property (
    (clk_en_i && !next_pins_s.clear && !next_pins_s.strobe_n) |=>
      latch_bits == shift_stage_bits)
    else $error("latch not transparent while strobe low");

  cascade_out_a: assert property (
    serial_out_o == shift_stage_bits[31])
    else $error("serial output differs from stage 31");

  latch_hold_a: assert property (
    (clk_en_i && !next_pins_s.clear && next_pins_s.strobe_n) |=>
      $stable(channel_terminal_o))
    else $error("switches changed while strobe high");

  clear_off_a: assert property (
    (clk_en_i && next_pins_s.clear) |=> channel_terminal_o == 32'h0000_0000)
    else $error("clear did not force all channels off");

  channel_pass_a: assert property (
    (clk_en_i && !next_pins_s.clear && !next_pins_s.strobe_n) |=>
      channel_terminal_o[31:1] == $past(next_shift[31:1]))
    else $error("channel does not follow its own stage");

  channel_zero_a: assert property (
    (clk_en_i && shift_rise && !next_pins_s.clear &&
     !next_pins_s.strobe_n) |=>
      channel_terminal_o[0] == $past(next_pins_s.serial_in))
    else $error("channel 0 does not follow its bit");
endmodule

// file: sscl_ctl_model.sv
// controller model: drives frames, strobe and clear on the latch pins
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
module sscl_ctl_model (
  // clock
  input  wire logic            clk_sys_i,
  // controller pins
  output sscl_pkg::sscl_pins_t pins_o
);
  import sscl_pkg::*;

  // =====================================================================
  // pin drivers; strobe idles high, shift clock stands low between frames
  initial pins_o = 4'h4;

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // data settles 4 edges before the rise and holds 4 edges after it
  task automatic shift_bit(input logic b);
    @(posedge clk_sys_i);
    pins_o.serial_in <= b;
    wait_cyc(4);
    pins_o.shift_clk <= 1'b1;
    wait_cyc(4);
    pins_o.shift_clk <= 1'b0;
    pins_o.serial_in <= ~b; // released: never leave a stale level
    wait_cyc(4);
  endtask

  // bit 31 goes first so that it ends in the last stage
  task automatic send_word(input sscl_word_t w);
    for (int i = 31; i >= 0; i--) begin
      shift_bit(w[i]);
    end
  endtask

  // both levels change on one edge, then settle past the filter
  task automatic set_pin(input logic clr, input logic stb_n);
    @(posedge clk_sys_i);
    pins_o.clear    <= clr;
    pins_o.strobe_n <= stb_n;
    wait_cyc(6);
  endtask
endmodule

// file: serial_switch_control_latch_tb.sv
// self-checking bench for the serial switch control latch
// assumes sscl_pkg and sscl_ctl_model are compiled before it
`timescale 1ns/1ps
module serial_switch_control_latch_tb;
  import sscl_pkg::*;

  // =====================================================================
  // clock, reset, wiring
  localparam sscl_word_t W1 = 32'hA5C3_0F1E;
  logic       clk_sys_i     = 1'b0;
  logic       rst_n_i       = 1'b0;
  logic       state_ready_i = 1'b0;
  logic       clk_en_i      = 1'b1;
  sscl_pins_t pins;
  sscl_word_t channel_terminal_o;
  sscl_word_t state_word_o;
  logic       serial_out_o;
  logic       state_valid_o;
  int         bad_count     = 0;
  int         n_checks      = 0;
  int         cycles        = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  sscl_ctl_model sscl_ctl_model_i (.clk_sys_i(clk_sys_i), .pins_o(pins));

  sscl_top sscl_top_i (
    .clk_sys_i          (clk_sys_i),
    .rst_n_i            (rst_n_i),
    .clk_en_i           (clk_en_i),
    .serial_in_i        (pins.serial_in),
    .shift_clk_i        (pins.shift_clk),
    .latch_strobe_n_i   (pins.strobe_n),
    .force_all_off_i    (pins.clear),
    .channel_terminal_o (channel_terminal_o),
    .serial_out_o       (serial_out_o),
    .state_word_o       (state_word_o),
    .state_valid_o      (state_valid_o),
    .state_ready_i      (state_ready_i)
  );

  // =====================================================================
  // hang guard: the run needs under 3000 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 10000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input string what, input sscl_word_t exp,
                     input sscl_word_t got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // =====================================================================
  // scenarios; each samples at the falling edge, clear of updates
  task automatic t_frame();
    @(negedge clk_sys_i);
    chk("channels", 32'h0, channel_terminal_o);
    chk("update valid", 32'h0, {31'h0, state_valid_o});
    sscl_ctl_model_i.send_word(W1);
    @(negedge clk_sys_i);
    chk("channels", 32'h0, channel_terminal_o);
    chk("serial out", {31'h0, W1[31]}, {31'h0, serial_out_o});
    sscl_ctl_model_i.set_pin(1'b0, 1'b0);
    @(negedge clk_sys_i);
    chk("channels", W1, channel_terminal_o);
    sscl_ctl_model_i.set_pin(1'b0, 1'b1);
    @(negedge clk_sys_i);
    chk("channels", W1, channel_terminal_o);
    chk("update valid", 32'h1, {31'h0, state_valid_o});
    chk("update word", W1, state_word_o);
    // receiver stalled until now; one take must empty the buffer
    @(posedge clk_sys_i);
    state_ready_i <= 1'b1;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("update valid", 32'h0, {31'h0, state_valid_o});
  endtask

  task automatic t_transparent();
    sscl_ctl_model_i.set_pin(1'b0, 1'b0);
    sscl_ctl_model_i.shift_bit(1'b1);
    @(negedge clk_sys_i);
    chk("channels", {W1[30:0], 1'b1}, channel_terminal_o);
    chk("serial out", {31'h0, W1[30]}, {31'h0, serial_out_o});
    sscl_ctl_model_i.set_pin(1'b0, 1'b1);
    sscl_ctl_model_i.shift_bit(1'b0);
    @(negedge clk_sys_i);
    chk("channels", {W1[30:0], 1'b1}, channel_terminal_o);
    chk("serial out", {31'h0, W1[29]}, {31'h0, serial_out_o});
  endtask

  task automatic t_clear();
    sscl_ctl_model_i.set_pin(1'b1, 1'b1);
    @(negedge clk_sys_i);
    chk("channels", 32'h0, channel_terminal_o);
    sscl_ctl_model_i.set_pin(1'b1, 1'b0);
    @(negedge clk_sys_i);
    chk("channels", 32'h0, channel_terminal_o);
    sscl_ctl_model_i.set_pin(1'b0, 1'b1);
    @(negedge clk_sys_i);
    chk("channels", 32'h0, channel_terminal_o);
    // shift register survives clear, so reopening shows it again
    sscl_ctl_model_i.set_pin(1'b0, 1'b0);
    @(negedge clk_sys_i);
    chk("channels", {W1[29:0], 2'b10}, channel_terminal_o);
  endtask

  // enable low: a whole shift pulse and a clear pulse must go unseen
  task automatic t_freeze();
    @(posedge clk_sys_i);
    clk_en_i <= 1'b0;
    sscl_ctl_model_i.shift_bit(1'b1);
    sscl_ctl_model_i.set_pin(1'b1, 1'b0);
    @(negedge clk_sys_i);
    chk("frozen channels", {W1[29:0], 2'b10}, channel_terminal_o);
    sscl_ctl_model_i.set_pin(1'b0, 1'b0);
    @(posedge clk_sys_i);
    clk_en_i <= 1'b1;
    sscl_ctl_model_i.shift_bit(1'b1);
    @(negedge clk_sys_i);
    chk("channels", {W1[28:0], 3'b101}, channel_terminal_o);
    chk("serial out", {31'h0, W1[28]}, {31'h0, serial_out_o});
  endtask

  // receiver stalled across two switch changes: neither word is lost
  task automatic t_stall();
    @(posedge clk_sys_i);
    state_ready_i <= 1'b0;
    sscl_ctl_model_i.shift_bit(1'b0);
    sscl_ctl_model_i.shift_bit(1'b1);
    @(negedge clk_sys_i);
    chk("channels", {W1[26:0], 5'b10101}, channel_terminal_o);
    chk("update valid", 32'h1, {31'h0, state_valid_o});
    chk("update word", {W1[27:0], 4'b1010}, state_word_o);
    // one take: the parked word moves up to the head
    @(posedge clk_sys_i);
    state_ready_i <= 1'b1;
    @(posedge clk_sys_i);
    state_ready_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("update valid", 32'h1, {31'h0, state_valid_o});
    chk("update word", {W1[26:0], 5'b10101}, state_word_o);
    @(posedge clk_sys_i);
    state_ready_i <= 1'b1;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("update valid", 32'h0, {31'h0, state_valid_o});
  endtask

  // =====================================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_frame();
    t_transparent();
    t_clear();
    t_freeze();
    t_stall();
    close_out();
  end
endmodule
